// file: common/cex_defs.vh
// Purpose: shared constants of the exception entry unit
// Assumes: included by bare name from rtl files
// Notes: definitions only
`ifndef CEX_DEFS_VH
`define CEX_DEFS_VH

// status word field positions
`define CEX_ST_MODE_HI 4
`define CEX_ST_T 5
`define CEX_ST_F 6
`define CEX_ST_I 7
`define CEX_ST_J 24
`define CEX_ST_NZCV_LO 28
`define CEX_ST_RESET 32'h000000D3

// mode field encodings
`define CEX_M_USR 5'h10
`define CEX_M_FIQ 5'h11
`define CEX_M_IRQ 5'h12
`define CEX_M_SVC 5'h13
`define CEX_M_ABT 5'h17
`define CEX_M_UND 5'h1B
`define CEX_M_SYS 5'h1F

// register bank selectors
`define CEX_B_USR 3'h0
`define CEX_B_FIQ 3'h1
`define CEX_B_IRQ 3'h2
`define CEX_B_SVC 3'h3
`define CEX_B_ABT 3'h4
`define CEX_B_UND 3'h5

// exception classes
`define CEX_C_NONE 3'h0
`define CEX_C_RST 3'h1
`define CEX_C_DABT 3'h2
`define CEX_C_FIQ 3'h3
`define CEX_C_IRQ 3'h4
`define CEX_C_PABT 3'h5
`define CEX_C_UND 3'h6
`define CEX_C_TRAP 3'h7

// vector addresses
`define CEX_V_RST 32'h00000000
`define CEX_V_UND 32'h00000004
`define CEX_V_TRAP 32'h00000008
`define CEX_V_PABT 32'h0000000C
`define CEX_V_DABT 32'h00000010
`define CEX_V_IRQ 32'h00000018
`define CEX_V_FIQ 32'h0000001C

// return address offsets
`define CEX_OFS_2 4'h2
`define CEX_OFS_4 4'h4
`define CEX_OFS_8 4'h8

// compact branch_link_switch hold length in cycles
`define CEX_BLX_CYCLES 2'h3
`endif

// file: rtl/cex_cond_check.v
// Purpose: evaluate a 4-bit condition field against the ALU flags
// Assumes: flags ordered N Z C V from msb to lsb
// Notes: purely combinational
`default_nettype none

module cex_cond_check (
    input wire [3:0] cond,
    input wire [3:0] nzcv,
    output reg pass
);

wire n = nzcv[3];
wire z = nzcv[2];
wire c = nzcv[1];
wire v = nzcv[0];

// pairs of codes share a test, the low bit inverts it
always @* begin
    case (cond[3:1])
        3'h0: pass = z;
        3'h1: pass = c;
        3'h2: pass = n;
        3'h3: pass = v;
        3'h4: pass = c & ~z;
        3'h5: pass = (n == v);
        3'h6: pass = ~z & (n == v);
        default: pass = 1'b1;
    endcase
    // the last code never passes, 4'hE always does
    if (cond[0]) begin
        pass = (cond[3:1] == 3'h7) ? 1'b0 : ~pass;
    end
end

endmodule // cex_cond_check

`default_nettype wire

// file: rtl/cex_entry.v
// Purpose: exception ranking, four-step entry, banked registers, return
// Assumes: one clock; pipeline signals share it; fiq/irq are asynchronous
// Notes: reads have one cycle latency; pipe_hold stalls the pipeline
//
// How it works
// - rank reset, data abort, fast, normal, prefetch abort, lowest group
// - lowest group never coincides, so it needs no internal order
// - data abort with fast interrupt: abort entry, then fast vector
// - full-width entry stores the class base address (abort, execute or decode) plus 4 or 8 in link
// - compact entry stores address plus 2, 4 or 8 by class
// - second step copies status word into target saved status word
// - third step writes the mode field of the target exception
// - final step redirects fetch to the exception vector
// - each exception mode has its own stack pointer register
// - entry sets interrupt disable flags to limit nesting
// - fast mode swaps in private registers for r8 to r14
// - fetch abort tags the instruction, taken only at execute
// - a flushed tagged instruction raises no prefetch abort
// - breakpoint instruction enters the prefetch abort exception
// - breakpoint taken at execute only, never after a flush
// - full-width instruction runs only if its condition passes
// - compact branch_link_switch pair takes three cycles
// - state saved only in the target mode's banked registers
`include "cex_defs.vh"
`default_nettype none

module cex_entry (
    input wire clk,
    input wire nrst,
    input wire reset_req,
    input wire fiq_req,
    input wire irq_req,
    input wire dabt_req,
    input wire [31:0] dabt_pc,
    input wire fetch_valid,
    input wire fetch_abort,
    input wire [31:0] fetch_pc,
    input wire id_breakpoint_instr,
    input wire id_undef,
    input wire id_trap,
    input wire id_blx_pair,
    input wire [3:0] id_cond,
    input wire pipe_advance,
    input wire branch_flush,
    input wire flag_we,
    input wire [3:0] flag_nzcv,
    input wire ret_req,
    input wire [31:0] ret_pc,
    input wire rf_we,
    input wire [3:0] rf_wr_idx,
    input wire [31:0] rf_wr_data,
    input wire [3:0] rf_rd_idx,
    output reg redirect,
    output reg [31:0] redirect_pc,
    output reg pipe_hold,
    output reg ex_exec,
    output reg [31:0] current_status_word,
    output reg [31:0] saved_status_word,
    output reg [31:0] rf_rd_data,
    output reg [2:0] exc_class
);

localparam S_IDLE = 3'h0;
localparam S_LINK = 3'h1;
localparam S_SAVE = 3'h2;
localparam S_MODE = 3'h3;
localparam S_VEC = 3'h4;

reg [2:0] state;
reg [2:0] next_state;
reg [2:0] cls;
reg [31:0] lr_q;
reg [31:0] vec_q;
reg after_vec;
reg rst_pend;
reg dabt_pend;
reg [31:0] dabt_pc_q;
reg fiq_s1, fiq_s2, irq_s1, irq_s2;
reg dec_valid, dec_abt;
reg [31:0] dec_pc;
reg ex_valid, ex_abt, ex_breakpoint_instr, ex_undef, ex_trap, ex_pass;
reg [31:0] ex_pc;
reg [1:0] blx_cnt;
reg [1:0] next_blx;
reg [2:0] pick;
reg [31:0] base;
reg [31:0] bank [0:29];
reg [31:0] sav [0:4];

wire [4:0] mode = current_status_word[`CEX_ST_MODE_HI:0];
wire compact = current_status_word[`CEX_ST_T];
wire fiq_off = current_status_word[`CEX_ST_F];
wire irq_off = current_status_word[`CEX_ST_I];
wire [3:0] flags = current_status_word[31:`CEX_ST_NZCV_LO];
wire cond_raw;

// bank selector of a mode; user and system share the plain set
function [2:0] bank_of;
    input [4:0] m;
    begin
        case (m)
            `CEX_M_FIQ: bank_of = `CEX_B_FIQ;
            `CEX_M_IRQ: bank_of = `CEX_B_IRQ;
            `CEX_M_SVC: bank_of = `CEX_B_SVC;
            `CEX_M_ABT: bank_of = `CEX_B_ABT;
            `CEX_M_UND: bank_of = `CEX_B_UND;
            default: bank_of = `CEX_B_USR;
        endcase
    end
endfunction

// physical slot: 0-14 plain, 15-21 fast r8-r14, then r13/r14 pairs
function [4:0] phys;
    input [2:0] b;
    input [3:0] idx;
    begin
        phys = {1'b0, idx};
        if (b == `CEX_B_FIQ && idx >= 4'h8 && idx <= 4'hE) begin
            phys = 5'h07 + {1'b0, idx};
        end else if (b != `CEX_B_USR && (idx == 4'hD || idx == 4'hE)) begin
            phys = {1'b0, b, 1'b0} + {1'b0, idx} + 5'h05;
        end
    end
endfunction

// target mode per class
function [4:0] mode_of;
    input [2:0] c;
    begin
        case (c)
            `CEX_C_FIQ: mode_of = `CEX_M_FIQ;
            `CEX_C_IRQ: mode_of = `CEX_M_IRQ;
            `CEX_C_DABT: mode_of = `CEX_M_ABT;
            `CEX_C_PABT: mode_of = `CEX_M_ABT;
            `CEX_C_UND: mode_of = `CEX_M_UND;
            default: mode_of = `CEX_M_SVC;
        endcase
    end
endfunction

function [31:0] vec_of;
    input [2:0] c;
    begin
        case (c)
            `CEX_C_DABT: vec_of = `CEX_V_DABT;
            `CEX_C_FIQ: vec_of = `CEX_V_FIQ;
            `CEX_C_IRQ: vec_of = `CEX_V_IRQ;
            `CEX_C_PABT: vec_of = `CEX_V_PABT;
            `CEX_C_UND: vec_of = `CEX_V_UND;
            `CEX_C_TRAP: vec_of = `CEX_V_TRAP;
            default: vec_of = `CEX_V_RST;
        endcase
    end
endfunction

// return offset per class and instruction state
function [3:0] ofs_of;
    input [2:0] c;
    input t;
    begin
        if (c == `CEX_C_DABT) begin
            ofs_of = `CEX_OFS_8;
        // compact traps resume one halfword on
        end else if (t && (c == `CEX_C_UND || c == `CEX_C_TRAP)) begin
            ofs_of = `CEX_OFS_2;
        end else begin
            ofs_of = `CEX_OFS_4;
        end
    end
endfunction

wire [2:0] cur_bank = bank_of(mode);
wire [2:0] tbank = bank_of(mode_of(cls));
wire cond_ok = compact | cond_raw;
wire take = (state == S_IDLE) && (pick != `CEX_C_NONE);
wire can_ret = (state == S_IDLE) && !take && ret_req &&
    (cur_bank != `CEX_B_USR);
wire flush = branch_flush | (state == S_VEC) | can_ret;
wire adv = pipe_advance & ~pipe_hold & ~take & ~flush;

// condition of the instruction entering execute
cex_cond_check u_cond (
    .cond(id_cond),
    .nzcv(flags),
    .pass(cond_raw)
);

// fixed ranking; execute-stage classes need a valid instruction
always @* begin
    pick = `CEX_C_NONE;
    if (rst_pend) begin
        pick = `CEX_C_RST;
    end else if (blx_cnt == 2'h0) begin
        if (dabt_pend) begin
            pick = `CEX_C_DABT;
        end else if (fiq_s2 && !fiq_off) begin
            pick = `CEX_C_FIQ;
        end else if (irq_s2 && !irq_off) begin
            pick = `CEX_C_IRQ;
        // tag seen only at execute breakpoint alike
        end else if (ex_valid && (ex_abt || ex_breakpoint_instr)) begin
            pick = `CEX_C_PABT;
        // undefined and trap exclusive, order moot
        end else if (ex_valid && ex_pass && ex_undef) begin
            pick = `CEX_C_UND;
        end else if (ex_valid && ex_pass && ex_trap) begin
            pick = `CEX_C_TRAP;
        end
    end
end

// address the link value builds on
always @* begin
    case (pick)
        `CEX_C_DABT: base = dabt_pc_q;
        `CEX_C_PABT, `CEX_C_UND, `CEX_C_TRAP: base = ex_pc;
        // straight after an entry, resume at that vector
        default: base = after_vec ? vec_q : dec_pc;
    endcase
end

// sequencer and stall length
always @* begin
    next_state = S_IDLE;
    case (state)
        S_IDLE: next_state = take ? S_LINK : S_IDLE;
        S_LINK: next_state = S_SAVE;
        S_SAVE: next_state = S_MODE;
        S_MODE: next_state = S_VEC;
        default: next_state = S_IDLE;
    endcase
    next_blx = blx_cnt;
    if (take) begin
        next_blx = 2'h0;
    end else if (blx_cnt != 2'h0) begin
        next_blx = blx_cnt - 2'h1;
    // pair holds execute for three cycles in all
    end else if (adv && dec_valid && compact && id_blx_pair) begin
        next_blx = `CEX_BLX_CYCLES;
    end
end

// request synchronisers; first stage feeds only the second
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        fiq_s1 <= 1'b0;
        fiq_s2 <= 1'b0;
        irq_s1 <= 1'b0;
        irq_s2 <= 1'b0;
    end else begin
        fiq_s1 <= fiq_req;
        fiq_s2 <= fiq_s1;
        irq_s1 <= irq_req;
        irq_s2 <= irq_s1;
    end
end

// pending latches; a new request beats the clear of the old one
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rst_pend <= 1'b1;
        dabt_pend <= 1'b0;
        dabt_pc_q <= 32'h00000000;
    end else begin
        if (reset_req) begin
            rst_pend <= 1'b1;
        end else if (take && pick == `CEX_C_RST) begin
            rst_pend <= 1'b0;
        end
        if (dabt_req) begin
            dabt_pend <= 1'b1;
            dabt_pc_q <= dabt_pc;
        end else if (take && pick == `CEX_C_DABT) begin
            dabt_pend <= 1'b0;
        end
    end
end

// decode and execute tags a flush drops them unraised
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        dec_valid <= 1'b0;
        dec_abt <= 1'b0;
        dec_pc <= 32'h00000000;
        ex_valid <= 1'b0;
        ex_abt <= 1'b0;
        ex_breakpoint_instr <= 1'b0;
        ex_undef <= 1'b0;
        ex_trap <= 1'b0;
        ex_pass <= 1'b0;
        ex_pc <= 32'h00000000;
        ex_exec <= 1'b0;
        blx_cnt <= 2'h0;
        after_vec <= 1'b0;
    end else begin
        blx_cnt <= next_blx;
        ex_exec <= 1'b0;
        if (flush) begin
            dec_valid <= 1'b0;
            ex_valid <= 1'b0;
            after_vec <= (state == S_VEC);
        end else if (adv) begin
            // fetch abort rides along as a tag
            dec_valid <= fetch_valid;
            dec_abt <= fetch_abort;
            dec_pc <= fetch_pc;
            ex_valid <= dec_valid;
            ex_abt <= dec_abt;
            ex_breakpoint_instr <= id_breakpoint_instr;
            ex_undef <= id_undef;
            ex_trap <= id_trap;
            ex_pass <= cond_ok;
            ex_pc <= dec_pc;
            ex_exec <= dec_valid & cond_ok & ~dec_abt & ~id_breakpoint_instr &
                ~id_undef & ~id_trap;
            after_vec <= 1'b0;
        end
    end
end

// entry steps, return and flag updates on the status word
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        state <= S_IDLE;
        cls <= `CEX_C_NONE;
        lr_q <= 32'h00000000;
        vec_q <= 32'h00000000;
        current_status_word <= `CEX_ST_RESET;
        redirect <= 1'b0;
        redirect_pc <= 32'h00000000;
        exc_class <= `CEX_C_NONE;
        pipe_hold <= 1'b1;
    end else begin
        state <= next_state;
        redirect <= 1'b0;
        pipe_hold <= (next_state != S_IDLE) | (next_blx != 2'h0);
        if (take) begin
            cls <= pick;
            lr_q <= base + {28'h0000000, ofs_of(pick, compact)};
        end else if (can_ret) begin
            current_status_word <= sav[cur_bank - 3'h1];
            redirect <= 1'b1;
            redirect_pc <= ret_pc;
        end else if (state == S_MODE) begin
            current_status_word[`CEX_ST_MODE_HI:0] <= mode_of(cls);
            // mask further normal interrupts, fast on reset/fast
            current_status_word[`CEX_ST_I] <= 1'b1;
            if (cls == `CEX_C_FIQ || cls == `CEX_C_RST) begin
                current_status_word[`CEX_ST_F] <= 1'b1;
            end
            current_status_word[`CEX_ST_T] <= 1'b0;
            current_status_word[`CEX_ST_J] <= 1'b0;
        end else if (state == S_VEC) begin
            redirect <= 1'b1;
            redirect_pc <= vec_of(cls);
            vec_q <= vec_of(cls);
            exc_class <= cls;
        end else if (flag_we) begin
            current_status_word[31:`CEX_ST_NZCV_LO] <= flag_nzcv;
        end
    end
end

// banked storage; entry writes win over pipeline writes
always @(posedge clk) begin
    if (state == S_LINK) begin
        // link goes to the target mode's own register
        bank[phys(tbank, 4'hE)] <= lr_q;
    end else if (rf_we && rf_wr_idx != 4'hF) begin
        bank[phys(cur_bank, rf_wr_idx)] <= rf_wr_data;
    end
    // copy status into the target saved status word
    if (state == S_SAVE && tbank != `CEX_B_USR) begin
        sav[tbank - 3'h1] <= current_status_word;
    end
end

// registered read ports through the current mode's view
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rf_rd_data <= 32'h00000000;
        saved_status_word <= 32'h00000000;
    end else begin
        rf_rd_data <= (rf_rd_idx == 4'hF) ? 32'h00000000 :
            bank[phys(cur_bank, rf_rd_idx)];
        saved_status_word <= (cur_bank == `CEX_B_USR) ? 32'h00000000 :
            sav[cur_bank - 3'h1];
    end
end

endmodule // cex_entry

`default_nettype wire

// file: verification/cex_entry_asserts.sv
// Purpose: port-level property checks for the exception entry unit
// Assumes: one clock domain, nrst low resets all state but the register and saved status banks
// Notes: an entry is a redirect that follows a held pipeline
`include "cex_defs.vh"
`default_nettype none

module cex_entry_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic dabt_req,
    input wire logic flag_we,
    input wire logic [3:0] flag_nzcv,
    input wire logic ret_req,
    input wire logic pipe_hold,
    input wire logic redirect,
    input wire logic [31:0] redirect_pc,
    input wire logic [31:0] current_status_word,
    input wire logic [31:0] saved_status_word,
    input wire logic [2:0] exc_class
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic was_held;
    wire logic ent;

    // a return redirect never follows a hold, which tells the two apart
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            was_held <= 1'b1;
        else
            was_held <= pipe_hold;
    end
    assign ent = redirect && was_held;

    // expected vector and mode of each class
    function automatic logic [31:0] vec(input logic [2:0] c);
        case (c)
            `CEX_C_DABT: return `CEX_V_DABT;
            `CEX_C_FIQ: return `CEX_V_FIQ;
            `CEX_C_IRQ: return `CEX_V_IRQ;
            `CEX_C_PABT: return `CEX_V_PABT;
            `CEX_C_UND: return `CEX_V_UND;
            `CEX_C_TRAP: return `CEX_V_TRAP;
            default: return `CEX_V_RST;
        endcase
    endfunction

    function automatic logic [4:0] mode(input logic [2:0] c);
        case (c)
            `CEX_C_FIQ: return `CEX_M_FIQ;
            `CEX_C_IRQ: return `CEX_M_IRQ;
            `CEX_C_UND: return `CEX_M_UND;
            `CEX_C_DABT, `CEX_C_PABT: return `CEX_M_ABT;
            default: return `CEX_M_SVC;
        endcase
    endfunction

    // link, save, mode and vector steps hold the pipe, then the redirect
    sequence entry_steps;
        pipe_hold[*4] ##1 (redirect && !pipe_hold);
    endsequence

    chk_pc_holds: assert property (!redirect |-> $stable(redirect_pc))
        else $error("redirect target moved without a redirect");
    chk_vector_fixed: assert property (ent |-> redirect_pc == vec(exc_class))
        else $error("entry vector does not match class");
    chk_mode_set: assert property (ent |-> current_status_word[4:0] ==
        mode(exc_class))
        else $error("entry mode does not match class");
    chk_irq_off: assert property (ent |-> current_status_word[7])
        else $error("interrupt disable not set on entry");
    chk_leave_state: assert property (ent |->
        !current_status_word[5] && !current_status_word[24])
        else $error("entry kept compact or bytecode state");
    chk_entry_len: assert property ($rose(pipe_hold) |-> entry_steps)
        else $error("entry step count wrong");
    chk_saved_copy: assert property ($rose(pipe_hold) |->
        ##4 saved_status_word == $past(current_status_word, 4))
        else $error("saved status differs from status at take");
    chk_dabt_rank: assert property ($rose(dabt_req) |->
        ##[1:16] (ent && exc_class == `CEX_C_DABT))
        else $error("data abort not taken in time");
    chk_mask_kept: assert property (ent && $past(current_status_word[7], 4)
        |-> exc_class != `CEX_C_IRQ)
        else $error("normal interrupt taken while masked");
    chk_flag_write: assert property (flag_we && !ret_req && !pipe_hold
        |=> current_status_word[31:28] == $past(flag_nzcv))
        else $error("flag write lost");
endmodule // cex_entry_chk

bind cex_entry cex_entry_chk u_chk (
    .clk(clk), .nrst(nrst), .dabt_req(dabt_req), .flag_we(flag_we),
    .flag_nzcv(flag_nzcv), .ret_req(ret_req), .pipe_hold(pipe_hold),
    .redirect(redirect), .redirect_pc(redirect_pc),
    .current_status_word(current_status_word),
    .saved_status_word(saved_status_word), .exc_class(exc_class)
);
`default_nettype wire

// file: verification/cex_src_model.sv
// Purpose: stand-in for the interrupt controller and memory system
// Assumes: requests change 2 ns after the rising edge
// Notes: abort address is scrambled whenever no abort is signalled
`default_nettype none

module cex_src_model (
    input wire logic clk,
    output logic reset_req,
    output logic fiq_req,
    output logic irq_req,
    output logic dabt_req,
    output logic [31:0] dabt_pc
);
    timeunit 1ns;
    timeprecision 100ps;

    // quiet at power-up
    initial begin
        reset_req = 1'b0;
        fiq_req = 1'b0;
        irq_req = 1'b0;
        dabt_req = 1'b0;
        dabt_pc = 32'hA5A5A5A5;
    end

    task automatic raise(input logic rst, input logic [31:0] pc);
        @(posedge clk);
        #2;
        reset_req = rst;
        dabt_req = 1'b1;
        dabt_pc = pc;
        @(posedge clk);
        #2;
        reset_req = 1'b0;
        dabt_req = 1'b0;
        dabt_pc = ~pc; // address no longer valid
    endtask

    // level requests, held until lowered
    task automatic ints(input logic lvl);
        irq_req = lvl;
        fiq_req = lvl;
    endtask
endmodule // cex_src_model
`default_nettype wire

// file: verification/tb.sv
// Purpose: self-checking bench for the exception entry unit
// Assumes: 40 MHz clock, inputs change 2 ns after the rising edge
// Notes: interrupts stay masked, so only their refusal is visible
`include "cex_defs.vh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, reset_req, fiq_req, irq_req, dabt_req, fetch_valid;
    logic fetch_abort, id_breakpoint_instr, id_undef, id_trap, pipe_advance;
    logic branch_flush, flag_we, ret_req, rf_we, ex, px;
    logic [31:0] dabt_pc, fetch_pc, ret_pc, rf_wr_data, pc, st, r13v, r8v;
    logic [3:0] id_cond, flag_nzcv, rf_wr_idx, rf_rd_idx, nz, cd;
    logic [1:0] kind;
    wire redirect, pipe_hold, ex_exec;
    wire [31:0] redirect_pc, current_status_word, saved_status_word;
    wire [31:0] rf_rd_data;
    wire [2:0] exc_class;
    int fails, num_checks, i;

    cex_entry dut (.clk(clk), .nrst(nrst), .reset_req(reset_req),
        .fiq_req(fiq_req), .irq_req(irq_req), .dabt_req(dabt_req),
        .dabt_pc(dabt_pc), .fetch_valid(fetch_valid),
        .fetch_abort(fetch_abort), .fetch_pc(fetch_pc), .id_breakpoint_instr(id_breakpoint_instr),
        .id_undef(id_undef), .id_trap(id_trap), .id_blx_pair(1'b0),
        .id_cond(id_cond), .pipe_advance(pipe_advance),
        .branch_flush(branch_flush), .flag_we(flag_we),
        .flag_nzcv(flag_nzcv), .ret_req(ret_req), .ret_pc(ret_pc),
        .rf_we(rf_we), .rf_wr_idx(rf_wr_idx), .rf_wr_data(rf_wr_data),
        .rf_rd_idx(rf_rd_idx), .redirect(redirect),
        .redirect_pc(redirect_pc), .pipe_hold(pipe_hold),
        .ex_exec(ex_exec), .current_status_word(current_status_word),
        .saved_status_word(saved_status_word), .rf_rd_data(rf_rd_data),
        .exc_class(exc_class));
    cex_src_model u_src (.clk(clk), .reset_req(reset_req),
        .fiq_req(fiq_req), .irq_req(irq_req), .dabt_req(dabt_req),
        .dabt_pc(dabt_pc));

    // 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic step;
        @(posedge clk);
        #2;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] e);
        rf_rd_idx = idx;
        step;
        chk(rf_rd_data, e, "register read");
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        rf_we = 1'b1;
        rf_wr_idx = idx;
        rf_wr_data = d;
        step;
        rf_we = 1'b0;
        step;
    endtask

    task automatic setf(input logic [3:0] v);
        flag_nzcv = v;
        flag_we = 1'b1;
        step;
        flag_we = 1'b0;
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            step;
            chk(32'(redirect), 32'h0, "unexpected redirect");
        end
    endtask

    // bounded wait, then class, vector and mode of the new handler
    task automatic entry(input logic [2:0] c, input logic [31:0] v,
                         input logic [4:0] m);
        int n;
        n = 0;
        // always move on first, so a redirect still standing is not reused
        do begin
            step;
            n++;
        end while (redirect !== 1'b1 && n < 20);
        chk(32'(redirect), 32'h1, "entry redirect");
        chk(32'(exc_class), 32'(c), "class");
        chk(redirect_pc, v, "vector");
        chk(32'(current_status_word[4:0]), 32'(m), "mode");
    endtask

    task automatic ret(input logic [31:0] p, input logic [31:0] s);
        ret_pc = p;
        ret_req = 1'b1;
        step;
        ret_req = 1'b0;
        ret_pc = ~p;
        chk(redirect_pc, p, "return target");
        chk(current_status_word, s, "restored status");
        step;
    endtask

    // one instruction through fetch, decode and into execute
    task automatic issue(input logic [31:0] p, input logic ab,
                         input logic [1:0] k, input logic fl,
                         input logic [3:0] c, output logic x);
        fetch_valid = 1'b1;
        fetch_pc = p;
        fetch_abort = ab;
        pipe_advance = 1'b1;
        step;
        fetch_valid = 1'b0;
        fetch_abort = 1'b0;
        fetch_pc = ~p;
        id_breakpoint_instr = (k == 2'h1);
        id_undef = (k == 2'h2);
        id_trap = (k == 2'h3);
        id_cond = c;
        branch_flush = fl;
        step;
        {id_breakpoint_instr, id_undef, id_trap, branch_flush, pipe_advance} = 5'h00;
        x = ex_exec;
        step;
        x = x | ex_exec;
    endtask

    // condition over N Z C V, each pair but the last inverted by bit 0
    function automatic logic cpass(input logic [3:0] c, input logic [3:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[2];
            3'h1: r = f[1];
            3'h2: r = f[3];
            3'h3: r = f[0];
            3'h4: r = f[1] & ~f[2];
            3'h5: r = (f[3] == f[0]);
            3'h6: r = ~f[2] & (f[3] == f[0]);
            default: r = 1'b1;
        endcase
        return (c[3:1] == 3'h7) ? 1'b1 : r ^ c[0];
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // main sequence
    initial begin
        void'($urandom(77));
        {nrst, fetch_valid, fetch_abort, id_breakpoint_instr, id_undef} = 5'h00;
        {id_trap, pipe_advance, branch_flush, flag_we, ret_req} = 5'h00;
        rf_we = 1'b0;
        {fetch_pc, ret_pc, rf_wr_data} = 96'h0;
        {id_cond, flag_nzcv, rf_wr_idx, rf_rd_idx} = 16'h0000;
        repeat (10) @(posedge clk);
        #2;
        chk(current_status_word, `CEX_ST_RESET, "reset status");
        chk({redirect, pipe_hold, exc_class}, 32'h8, "reset outputs");
        nrst = 1'b1;
        entry(`CEX_C_RST, `CEX_V_RST, `CEX_M_SVC);
        r13v = $urandom;
        r8v = $urandom;
        wr(4'hD, r13v);
        wr(4'h8, r8v);
        nz = $urandom;
        setf(nz);
        st = {nz, 28'h00000D3};
        pc = $urandom & 32'hFFFFFFFC;
        u_src.raise(1'b1, pc);
        entry(`CEX_C_RST, `CEX_V_RST, `CEX_M_SVC);
        entry(`CEX_C_DABT, `CEX_V_DABT, `CEX_M_ABT);
        rd(4'hE, pc + 32'h8);
        chk(saved_status_word, st, "saved status");
        wr(4'hD, ~r13v);
        ret(pc, st);
        rd(4'hD, r13v);
        rd(4'h8, r8v);
        // random conditions and classes, mixed with plain instructions
        for (i = 0; i < 16; i++) begin
            nz = $urandom;
            cd = $urandom_range(14, 0);
            kind = $urandom_range(2, 0);
            if (kind != 2'h0)
                kind = kind + 2'h1;
            setf(nz);
            st = {nz, 28'h00000D3};
            pc = $urandom & 32'hFFFFFFFC;
            px = cpass(cd, nz);
            issue(pc, 1'b0, kind, 1'b0, cd, ex);
            if (kind == 2'h0)
                chk(32'(ex), 32'(px), "execute flag");
            else if (!px)
                quiet(8);
            else begin
                if (kind == 2'h2)
                    entry(`CEX_C_UND, `CEX_V_UND, `CEX_M_UND);
                else
                    entry(`CEX_C_TRAP, `CEX_V_TRAP, `CEX_M_SVC);
                rd(4'hE, pc + 32'h4);
                ret(pc + 32'h4, st);
            end
        end
        // fetch abort, breakpoint, each also flushed before execute
        for (i = 0; i < 4; i++) begin
            pc = $urandom & 32'hFFFFFFFC;
            issue(pc, !i[0], {1'b0, i[0]}, i[1], 4'hE, ex);
            if (i[1])
                quiet(10);
            else begin
                entry(`CEX_C_PABT, `CEX_V_PABT, `CEX_M_ABT);
                rd(4'hE, pc + 32'h4);
                ret(pc, st);
            end
        end
        u_src.ints(1'b1);
        quiet(12);
        u_src.ints(1'b0);
        test_done;
    end

    // watchdog: the tests need well under 2000 cycles
    initial begin
        #(25 * 6000);
        fails++;
        test_done;
    end
endmodule // tb
`default_nettype wire
